// file: logic/flow_universal_output.sv
`timescale 1ns/100ps
module flow_universal_output
	import uout_pkg::*;
#(
	parameter int CYC_PER_SEC = CLK_HZ
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_sys_rst,
	input  wire out_mode_t         i_out_mode,
	input  wire logic [FLOW_W-1:0] i_flow_rate,
	input  wire logic [FLOW_W-1:0] i_flow_lower,
	input  wire logic [FLOW_W-1:0] i_flow_upper,
	input  wire logic [FMAX_W-1:0] i_freq_max,
	input  wire logic [TAU_W-1:0]  i_pulse_ms,
	input  wire logic [VOL_W-1:0]  i_vol_last_sec,
	input  wire logic              i_flow_over,
	input  wire logic              i_active_high,
	input  wire logic              i_event,
	input  wire logic              i_batch_sel,
	input  wire logic              i_batching,
	input  wire logic              i_batch_done,
	output logic                   o_uout,
	output logic [25:0]            o_pulse_volume_weight
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic level_of(input logic act, input logic present);
		return present ? act : ~act;
	endfunction

	// ------------------------------------------------------------
	// frequency mode
	// ------------------------------------------------------------
	logic [FMAX_W-1:0] fmax_c;
	logic [FLOW_W-1:0] span;
	logic [FLOW_W-1:0] q_eff;
	logic [28:0]       step;
	logic [41:0]       limit;
	logic [42:0]       acc_r;
	logic [42:0]       acc_sum;
	logic              freq_lvl_r;
	logic              span_ok;

	always_comb begin
		fmax_c = (i_freq_max > FMAX_LIMIT_HZ) ? FMAX_LIMIT_HZ
			: i_freq_max; // see [RL2]
		span_ok = i_flow_upper > i_flow_lower;
		span = span_ok ? i_flow_upper - i_flow_lower : '0;
		if (!span_ok || i_flow_rate <= i_flow_lower)
			q_eff = '0; // see [RL12]
		else if (i_flow_rate >= i_flow_upper)
			q_eff = span; // see [RL12]
		else
			q_eff = i_flow_rate - i_flow_lower;
		// scale factor fmax/span applied as a rate ratio, see [RL3]
		step = 29'(SQUARE_RATIO) * 29'(fmax_c) * 29'(q_eff);
		limit = 42'(span) * 42'(CYC_PER_SEC);
		acc_sum = acc_r + 43'(step);
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			acc_r <= '0;
			freq_lvl_r <= 1'h0;
		end else if (i_out_mode != MODE_FREQ || !span_ok) begin
			acc_r <= '0;
			freq_lvl_r <= 1'h0;
		end else if (acc_sum >= 43'(limit)) begin
			acc_r <= acc_sum - 43'(limit);
			freq_lvl_r <= ~freq_lvl_r; // see [RL1]
		end else begin
			acc_r <= acc_sum;
		end
	end

	// ------------------------------------------------------------
	// pulse width, weight and one-second tick
	// ------------------------------------------------------------
	logic [TAU_W-1:0] tau_c;
	logic [TMR_W-1:0] tau_cyc;
	logic [25:0]      sec_cnt_r;
	logic             sec_tick;

	always_comb begin
		if (i_pulse_ms < TAU_MIN_MS)
			tau_c = TAU_MIN_MS; // see [RL6]
		else if (i_pulse_ms > TAU_MAX_MS)
			tau_c = TAU_MAX_MS; // see [RL6]
		else
			tau_c = i_pulse_ms;
		tau_cyc = TMR_W'(tau_c) * TMR_W'(CYC_PER_MS);
		sec_tick = sec_cnt_r == 26'(CYC_PER_SEC - 1);
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_pulse_volume_weight <= '0;
		else
			o_pulse_volume_weight <= 26'(SQUARE_RATIO) * 26'(i_flow_upper)
				* 26'(tau_c); // see [RL6]
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			sec_cnt_r <= '0;
		else if (sec_tick)
			sec_cnt_r <= '0;
		else
			sec_cnt_r <= sec_cnt_r + 26'h0000001;
	end

	// ------------------------------------------------------------
	// volume credit and pulse generator
	// ------------------------------------------------------------
	logic [35:0] credit_r;
	logic        burst_mode;
	logic        batch_pend_r;
	logic        batch_req;
	logic        burst_req;
	logic        pg_start;
	pg_state_t   pg_st_r;
	logic [TMR_W-1:0] tmr_r;

	always_comb begin
		burst_mode = i_out_mode == MODE_PULSE && !i_batch_sel;
		batch_req = i_out_mode == MODE_PULSE && i_batch_sel
			&& batch_pend_r;
		burst_req = burst_mode && !i_flow_over // see [RL11]
			&& o_pulse_volume_weight != '0
			&& credit_r >= 36'(o_pulse_volume_weight); // see [RL4]
		pg_start = pg_st_r == PG_IDLE && (burst_req || batch_req);
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			credit_r <= '0;
		else if (!burst_mode)
			credit_r <= '0;
		else if (sec_tick && !i_flow_over) // see [RL11]
			credit_r <= credit_r + 36'(i_vol_last_sec)
				* 36'(MILLI_PER_UNIT)
				- (pg_start ? 36'(o_pulse_volume_weight) : 36'h0);
		else if (pg_start)
			credit_r <= credit_r - 36'(o_pulse_volume_weight); // see [RL4]
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			batch_pend_r <= 1'h0;
		else if (i_batch_done && i_out_mode == MODE_PULSE && i_batch_sel)
			batch_pend_r <= 1'h1; // see [RL8]
		else if (pg_start)
			batch_pend_r <= 1'h0;
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pg_st_r <= PG_IDLE;
			tmr_r <= '0;
		end else if (i_out_mode != MODE_PULSE) begin
			pg_st_r <= PG_IDLE;
			tmr_r <= '0;
		end else begin
			case (pg_st_r)
				PG_IDLE: begin
					if (pg_start) begin
						pg_st_r <= PG_HIGH;
						tmr_r <= tau_cyc - TMR_W'(1); // see [RL5]
					end
				end
				PG_HIGH: begin
					if (tmr_r == '0) begin
						pg_st_r <= PG_LOW;
						tmr_r <= tau_cyc - TMR_W'(1); // see [RL5]
					end else begin
						tmr_r <= tmr_r - TMR_W'(1);
					end
				end
				PG_LOW: begin
					if (tmr_r == '0)
						pg_st_r <= PG_IDLE;
					else
						tmr_r <= tmr_r - TMR_W'(1);
				end
				default: begin
					pg_st_r <= PG_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// output select
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_uout <= 1'h0;
		end else begin
			case (i_out_mode) // see [RL10]
				MODE_FREQ:  o_uout <= freq_lvl_r;
				MODE_PULSE: o_uout <= pg_st_r == PG_HIGH;
				MODE_LOGIC: o_uout <= i_batch_sel
					? level_of(i_active_high, i_batching) // see [RL9]
					: level_of(i_active_high, i_event); // see [RL7]
				default:    o_uout <= 1'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_off_low;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_out_mode == MODE_OFF |=> !o_uout;
	endproperty
	a_off_low: assert property (p_off_low) // see [RL10]
		else $error("disabled output not low");

	property p_logic_level;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_out_mode == MODE_LOGIC && !i_batch_sel
			|=> o_uout == ($past(i_event) ? $past(i_active_high)
				: !$past(i_active_high));
	endproperty
	a_logic_level: assert property (p_logic_level) // see [RL7]
		else $error("logical level wrong");

	property p_batch_level;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_out_mode == MODE_LOGIC && i_batch_sel && $changed(i_batching)
			&& $stable(i_active_high) ##1 i_out_mode == MODE_LOGIC
			|-> $changed(o_uout);
	endproperty
	a_batch_level: assert property (p_batch_level) // see [RL9]
		else $error("batch level did not change");

	property p_high_len;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		pg_st_r == PG_IDLE ##1 pg_st_r == PG_HIGH
			|-> tmr_r == tau_cyc - TMR_W'(1) || $changed(i_pulse_ms);
	endproperty
	a_high_len: assert property (p_high_len) // see [RL5]
		else $error("pulse width load wrong");

	property p_overflow_hold;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		sec_tick && i_flow_over |=> credit_r <= $past(credit_r);
	endproperty
	a_overflow_hold: assert property (p_overflow_hold) // see [RL11]
		else $error("credit grew during overflow");

	property p_below_lower;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_out_mode == MODE_FREQ && i_flow_rate <= i_flow_lower
			&& !freq_lvl_r |=> !freq_lvl_r;
	endproperty
	a_below_lower: assert property (p_below_lower) // see [RL12]
		else $error("pulses below lower threshold");

	property p_fmax_cap;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		fmax_c <= FMAX_LIMIT_HZ && (i_freq_max > FMAX_LIMIT_HZ
			|| fmax_c == i_freq_max);
	endproperty
	a_fmax_cap: assert property (p_fmax_cap) // see [RL2]
		else $error("max frequency not capped");

	property p_batch_pulse;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_batch_done && i_batch_sel && pg_st_r == PG_IDLE
			&& i_out_mode == MODE_PULSE ##1 i_out_mode == MODE_PULSE
			|-> ##1 pg_st_r == PG_HIGH;
	endproperty
	a_batch_pulse: assert property (p_batch_pulse) // see [RL8]
		else $error("batch pulse not started");

	property p_weight;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		1'h1 |=> o_pulse_volume_weight == 26'(SQUARE_RATIO)
			* 26'($past(i_flow_upper)) * 26'($past(tau_c));
	endproperty
	a_weight: assert property (p_weight) // see [RL6]
		else $error("pulse weight wrong");

endmodule // flow_universal_output

// file: logic/uout_pkg.sv
// How it works
// [RL1] frequency mode gives a 50% duty square wave at a rate set by flow.
// [RL2] lower threshold maps to 0 Hz, upper to max frequency, capped 3000 Hz.
// [RL3] the scale factor comes from both thresholds and max frequency.
// [RL4] pulse mode sends, each second, last second's volume over the weight.
// [RL5] burst pulses are square, period twice the width, at most 500 Hz.
// [RL6] pulse width is 1 to 500 ms; weight comes from upper flow and width.
// [RL7] logical mode drives the active level while the event is present.
// [RL8] pulse-mode batch signalling sends one pulse when a batch completes.
// [RL9] logical-mode batch signalling changes level at batch start and stop.
// [RL10] function, mode and parameters are set by ports; output can be off.
// [RL11] bursts are suppressed while flow is above the overflow limit.
// [RL12] flow below lower gives no pulses, above upper holds max frequency.
package uout_pkg;
	localparam int FLOW_W          = 16;
	localparam int FMAX_W          = 12;
	localparam int TAU_W           = 9;
	localparam int VOL_W           = 24;
	localparam int TMR_W           = 25;
	localparam int CLK_PERIOD_NS   = 20;
	localparam int MS_NS           = 1000000;
	localparam int CYC_PER_MS      = MS_NS / CLK_PERIOD_NS;
	localparam int CLK_HZ          = 50000000;
	localparam int MILLI_PER_UNIT  = 1000;
	localparam int SQUARE_RATIO    = 2;
	localparam logic [FMAX_W-1:0] FMAX_LIMIT_HZ = 12'hBB8;
	localparam logic [TAU_W-1:0]  TAU_MIN_MS    = 9'h001;
	localparam logic [TAU_W-1:0]  TAU_MAX_MS    = 9'h1F4;
	localparam int BURST_MAX_HZ    = 500;
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_FREQ,
		MODE_PULSE,
		MODE_LOGIC
	} out_mode_t;
	typedef enum logic [1:0] {
		PG_IDLE,
		PG_HIGH,
		PG_LOW
	} pg_state_t;
endpackage

// file: verif/pulse_receiver.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side receiver timing high phases
// ----------------------------------------
module pulse_receiver (
	input  wire logic i_ref_clk,
	input  wire logic i_line,
	output int        o_hi_len,
	output int        o_falls
);
	int   cnt_r;
	logic line_r;
	initial begin
		cnt_r = 0;
		line_r = 0;
		o_hi_len = 0;
		o_falls = 0;
	end
	always @(posedge i_ref_clk) begin
		line_r <= i_line;
		if (i_line)
			cnt_r <= cnt_r + 1;
		if (!i_line && line_r) begin
			o_hi_len <= cnt_r;
			o_falls  <= o_falls + 1;
			cnt_r    <= 0;
		end
	end
endmodule // pulse_receiver

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top import uout_pkg::*;;
	localparam int SEC = 30000;
	logic              clk = 0;
	logic              rst = 1;
	out_mode_t         mode;
	logic [FLOW_W-1:0] rate, lower, upper;
	logic [FMAX_W-1:0] fmax;
	logic [TAU_W-1:0]  tau;
	logic [VOL_W-1:0]  vol;
	logic              over, act_hi, evt, sel, batching, done, uout;
	logic [25:0]       weight;
	int                hi_len, falls, n0;
	int                n_mismatch = 0;
	int                tests_run = 0;

	always #10 clk = ~clk;

	flow_universal_output #(.CYC_PER_SEC(SEC)) u_dut (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_out_mode(mode),
		.i_flow_rate(rate), .i_flow_lower(lower), .i_flow_upper(upper),
		.i_freq_max(fmax), .i_pulse_ms(tau), .i_vol_last_sec(vol),
		.i_flow_over(over), .i_active_high(act_hi), .i_event(evt),
		.i_batch_sel(sel), .i_batching(batching), .i_batch_done(done),
		.o_uout(uout), .o_pulse_volume_weight(weight));
	pulse_receiver u_rx (.i_ref_clk(clk), .i_line(uout),
		.o_hi_len(hi_len), .o_falls(falls));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task test_done;
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task chk_rng(input string nm, input int exp, input int got);
		tests_run++;
		if (got < exp - 1 || got > exp + 1) begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wait_fall(input int lim);
		int f0;
		f0 = falls;
		for (int i = 0; i < lim && falls == f0; i++)
			@(negedge clk);
		chk("fall seen", 1, falls != f0);
	endtask

	initial begin
		cyc(90000);
		n_mismatch++;
		test_done;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		mode = MODE_OFF;
		rate = 16'h0000;
		lower = 16'h0064;
		upper = 16'h012C;
		fmax = 12'hBB8;
		tau = 9'h001;
		vol = 24'h000000;
		{over, act_hi, evt, sel, batching, done} = 6'h00;
		cyc(4);
		chk("uout in reset", 0, uout);
		chk("weight in reset", 0, weight);
		rst = 0;
		cyc(2);
		chk("weight", 2 * upper * tau, weight);
		tau = 9'h1F4;
		cyc(2);
		chk("weight", 2 * upper * tau, weight);
		tau = 9'h001;
		mode = MODE_LOGIC;
		for (int i = 0; i < 8; i++) begin
			act_hi = i[2];
			sel = i[1];
			evt = i[1] ^ i[0];
			batching = ~evt;
			cyc(2);
			chk("logic level", i[0] ? i[2] : !i[2], uout);
		end
		mode = MODE_OFF;
		{act_hi, evt, sel} = 3'h6;
		cyc(2);
		chk("disabled", 0, uout);
		mode = MODE_PULSE;
		over = 1;
		vol = 24'h0003E8;
		n0 = falls;
		cyc(SEC + 10);
		chk("bursts under overflow", n0, falls);
		chk("line under overflow", 0, uout);
		vol = 24'h000000;
		rate = 16'h0190;
		fmax = 12'hFA0;
		mode = MODE_FREQ;
		wait_fall(100);
		chk("half period at cap", SEC / 6000, hi_len);
		mode = MODE_OFF;
		cyc(2);
		rate = 16'h00FA;
		fmax = 12'hBB8;
		mode = MODE_FREQ;
		wait_fall(100);
		chk_rng("half period", SEC / 4500, hi_len);
		mode = MODE_OFF;
		cyc(2);
		rate = 16'h0032;
		mode = MODE_FREQ;
		n0 = falls;
		cyc(200);
		chk("below lower", n0, falls);
		chk("below lower level", 0, uout);
		mode = MODE_PULSE;
		sel = 1;
		over = 0;
		done = 1;
		cyc(1);
		done = 0;
		wait_fall(60000);
		chk("batch pulse", CYC_PER_MS * tau, hi_len);
		test_done;
	end
endmodule // tb_top
